// *** src/ext_trip_and_breaker_fail_supervisor.v ***
// top: four external protection stages, breaker failure supervisor, apb
`timescale 1ns/1ps
`default_nettype none
`include "prot_consts.vh"
module ext_trip_and_breaker_fail_supervisor #(
	parameter [23:0] BF_TIME_RESET = `BF_TIME_CYCLES
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [3:0]  ext_block_src1,
	input  wire [3:0]  ext_block_src2,
	input  wire [3:0]  ext_trip_order_block_src,
	input  wire [3:0]  alarm_src,
	input  wire [3:0]  trip_src,
	input  wire        all_trips,
	input  wire        current_trips,
	input  wire        external_trips,
	input  wire [2:0]  extra_trigger,
	input  wire        current_below_threshold,
	input  wire        position_open,
	input  wire        freq_deviation_high,
	output reg  [3:0]  stage_active,
	output reg  [3:0]  ext_blocked_flag,
	output reg  [3:0]  trip_order_blocked_flag,
	output reg  [3:0]  ext_trip_order_blocked_flag,
	output reg  [3:0]  stage_alarm,
	output reg  [3:0]  stage_trip,
	output reg  [3:0]  breaker_open_order,
	output reg         breaker_failure_trip,
	output reg         breaker_failure_lockout,
	output reg         supervisor_rejected,
	output reg         supervisor_running
);
	localparam NSRC = 29;

	// apb decode
	wire        setup_ph;
	wire        wr_acc;
	wire        addr_ok;

	// synchronised pins
	wire [NSRC-1:0] raw_pins;
	reg  [NSRC-1:0] pin_meta;
	reg  [NSRC-1:0] pin_sync;

	wire [3:0] s_blk1;
	wire [3:0] s_blk2;
	wire [3:0] s_ordblk;
	wire [3:0] s_alarm;
	wire [3:0] s_trip;
	wire       s_all;
	wire       s_cur;
	wire       s_ext;
	wire [2:0] s_extra;
	wire       s_below;
	wire       s_open;
	wire       s_freq;

	// settings
	reg  [15:0]        stage_cfg;
	reg  [3:0]         bf_cfg;
	reg  [`TIMER_W-1:0] bf_time;

	// stage flag collection
	wire [6:0]  flags [0:3];
	wire [31:0] stage_status;
	wire [31:0] stage_inputs;

	// supervisor
	reg  [1:0]          bf_state;
	reg  [1:0]          next_bf_state;
	reg  [`TIMER_W-1:0] bf_count;
	reg  [`TIMER_W-1:0] next_bf_count;
	reg                 lockout_set;
	reg                 lockout_clr;
	wire [1:0]          scheme;
	wire [1:0]          mode;
	wire                stage_orders;
	reg                 mode_trigger;
	wire                trigger;
	wire                cur_blocked;
	reg                 opened;
	reg  [31:0]         rd_mux;

	// every pin crosses two flops before any logic looks at it
	assign raw_pins = {freq_deviation_high, position_open,
		current_below_threshold, extra_trigger, external_trips,
		current_trips, all_trips, trip_src, alarm_src,
		ext_trip_order_block_src, ext_block_src2, ext_block_src1};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= {NSRC{1'b0}};
			pin_sync <= {NSRC{1'b0}};
		end else begin
			pin_meta <= raw_pins;
			pin_sync <= pin_meta;
		end
	end

	// split the synchronised bus back into its sources
	assign s_blk1   = pin_sync[3:0];
	assign s_blk2   = pin_sync[7:4];
	assign s_ordblk = pin_sync[11:8];
	assign s_alarm  = pin_sync[15:12];
	assign s_trip   = pin_sync[19:16];
	assign s_all    = pin_sync[20];
	assign s_cur    = pin_sync[21];
	assign s_ext    = pin_sync[22];
	assign s_extra  = pin_sync[25:23];
	assign s_below  = pin_sync[26];
	assign s_open   = pin_sync[27];
	assign s_freq   = pin_sync[28];

	// four identical stages
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : stage
			external_protection_stage u_stage (
				.pclk                           (pclk),
				.presetn                        (presetn),
				.cfg                            (stage_cfg[g*4 +: 4]),
				.ext_block_src1_state           (s_blk1[g]),
				.ext_block_src2_state           (s_blk2[g]),
				.ext_trip_order_block_src_state (s_ordblk[g]),
				.alarm_src_state                (s_alarm[g]),
				.trip_src_state                 (s_trip[g]),
				.flags                          (flags[g])
			);
			// status and input states, one byte per stage
			assign stage_status[g*8 +: 8] = {1'b0, flags[g]};
			assign stage_inputs[g*8 +: 8] = {3'h0, s_trip[g],
				s_alarm[g], s_ordblk[g], s_blk2[g], s_blk1[g]};
		end
	endgenerate

	// stage flags to top ports, through one more flop stage
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_active                <= 4'h0;
			ext_blocked_flag            <= 4'h0;
			trip_order_blocked_flag     <= 4'h0;
			ext_trip_order_blocked_flag <= 4'h0;
			stage_alarm                 <= 4'h0;
			stage_trip                  <= 4'h0;
			breaker_open_order          <= 4'h0;
		end else begin
			for (k = 0; k < 4; k = k + 1) begin
				stage_active[k]                <= flags[k][0];
				ext_blocked_flag[k]            <= flags[k][1];
				trip_order_blocked_flag[k]     <= flags[k][2];
				ext_trip_order_blocked_flag[k] <= flags[k][3];
				stage_alarm[k]                 <= flags[k][4];
				stage_trip[k]                  <= flags[k][5];
				breaker_open_order[k]          <= flags[k][6];
			end
		end
	end

	// trigger selection; extra triggers act in every mode
	assign scheme = bf_cfg[`BF_SCHEME_LSB +: 2];
	assign mode = bf_cfg[`BF_MODE_LSB +: 2];
	assign stage_orders = |{flags[3][6], flags[2][6], flags[1][6],
		flags[0][6]};

	always @* begin
		case (mode)
			`MODE_ALL:      mode_trigger = s_all | s_cur | s_ext |
				stage_orders;
			`MODE_CURRENT:  mode_trigger = s_cur;
			`MODE_EXTERNAL: mode_trigger = s_ext | stage_orders;
			default:        mode_trigger = 1'b0;
		endcase
	end

	// a current-only scheme out of frequency range does not supervise
	assign cur_blocked = s_freq & (scheme == `SCHEME_CURRENT);
	assign trigger = (mode_trigger | (|s_extra)) & ~cur_blocked;

	// opening per scheme; combined falls back to position when off
	// frequency, else failure needs current high and contacts closed
	always @* begin
		case (scheme)
			`SCHEME_CURRENT: opened = s_below;
			`SCHEME_BOTH:    opened = s_open | (s_below & ~s_freq);
			default:         opened = s_open;
		endcase
	end

	// supervisor state machine and timer
	always @* begin
		next_bf_state = bf_state;
		next_bf_count = bf_count;
		lockout_set = 1'b0;
		case (bf_state)
			`BF_STANDBY: begin
				if (trigger) begin
					next_bf_state = `BF_RUNNING;
					next_bf_count = bf_time;
				end
			end
			`BF_RUNNING: begin
				// runs on whether or not the trigger is still there
				if (opened && trigger) begin
					next_bf_state = `BF_REJECTED;
				end else if (opened) begin
					next_bf_state = `BF_STANDBY;
				end else if (bf_count == {`TIMER_W{1'b0}}) begin
					// not opened at expiry: criterion persists
					next_bf_state = `BF_FAILED;
					lockout_set = 1'b1;
				end else begin
					next_bf_count = bf_count - 1'b1;
				end
			end
			`BF_REJECTED: begin
				if (!trigger) begin
					next_bf_state = `BF_STANDBY;
				end else begin
					next_bf_state = `BF_REJECTED;
				end
			end
			`BF_FAILED: begin
				// trip holds while triggers stand, then stand-by
				if (!trigger) begin
					next_bf_state = `BF_STANDBY;
				end
			end
			default: next_bf_state = `BF_STANDBY;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bf_state <= `BF_STANDBY;
			bf_count <= {`TIMER_W{1'b0}};
		end else begin
			bf_state <= next_bf_state;
			bf_count <= next_bf_count;
		end
	end

	// supervisor outputs; trip and lockout rise on the same edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			breaker_failure_trip    <= 1'b0;
			breaker_failure_lockout <= 1'b0;
			supervisor_rejected     <= 1'b0;
			supervisor_running      <= 1'b0;
		end else begin
			breaker_failure_trip <= (next_bf_state == `BF_FAILED);
			supervisor_rejected  <= (next_bf_state == `BF_REJECTED);
			supervisor_running   <= (next_bf_state == `BF_RUNNING);
			// a new failure wins over an acknowledge in the same cycle
			if (lockout_set) begin
				breaker_failure_lockout <= 1'b1;
			end else if (lockout_clr) begin
				breaker_failure_lockout <= 1'b0;
			end
		end
	end

	// apb: no wait states, pready rises in the access phase
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;
	assign addr_ok = (paddr == `ADDR_STAGE_CFG) |
		(paddr == `ADDR_STAGE_STATUS) | (paddr == `ADDR_STAGE_INPUTS) |
		(paddr == `ADDR_BF_CFG) | (paddr == `ADDR_BF_TIME) |
		(paddr == `ADDR_BF_STATUS) | (paddr == `ADDR_BF_ACK);

	// read data captured at setup, so prdata stays a flop output
	always @* begin
		case (paddr)
			`ADDR_STAGE_CFG:    rd_mux = {16'h0000, stage_cfg};
			`ADDR_STAGE_STATUS: rd_mux = stage_status;
			`ADDR_STAGE_INPUTS: rd_mux = stage_inputs;
			`ADDR_BF_CFG:       rd_mux = {28'h0000000, bf_cfg};
			`ADDR_BF_TIME:      rd_mux = {8'h00, bf_time};
			`ADDR_BF_STATUS:    rd_mux = {26'h0000000, supervisor_running,
				supervisor_rejected, breaker_failure_lockout,
				breaker_failure_trip, bf_state};
			default:            rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~addr_ok;
			if (setup_ph && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// register writes at the access edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_cfg   <= `STAGE_CFG_RESET;
			bf_cfg      <= `BF_CFG_RESET;
			bf_time     <= BF_TIME_RESET;
			lockout_clr <= 1'b0;
		end else begin
			lockout_clr <= 1'b0;
			if (wr_acc && paddr == `ADDR_STAGE_CFG) begin
				stage_cfg <= pwdata[15:0];
			end
			if (wr_acc && paddr == `ADDR_BF_CFG) begin
				bf_cfg <= pwdata[3:0];
			end
			if (wr_acc && paddr == `ADDR_BF_TIME) begin
				bf_time <= pwdata[23:0];
			end
			// acknowledge is the only way out of lockout
			if (wr_acc && paddr == `ADDR_BF_ACK) begin
				lockout_clr <= pwdata[0];
			end
		end
	end
endmodule // ext_trip_and_breaker_fail_supervisor
`default_nettype wire

// *** src/prot_consts.vh ***
// register map, field layout, reset values and timing for the supervisor
// Contract
// - stage function setting, default off, silences stage
// - external block acts only when permitted
// - permanent order block suppresses order, flags it
// - permitted external order block suppresses, flags
// - stage exposes five input source states
// - stage drives seven separate output flags
// - trigger starts supervision timer at once
// - timer keeps running after trigger drops
// - expiry without stop raises failure trip
// - detected opening stops timer, per scheme
// - failure declared when scheme criterion persists
// - opening with trigger still present: rejected
// - rejected held until triggers drop
// - triggers dropped returns to stand-by
// - lockout with trip, held until acknowledged
// - four identical external protection stages
// - trip follows source when active, unblocked
// - frequency deviation blocks current scheme
// - trigger mode select plus three extra triggers
`ifndef PROT_CONSTS_VH
`define PROT_CONSTS_VH

// apb byte offsets
`define ADDR_STAGE_CFG     12'h000
`define ADDR_STAGE_STATUS  12'h004
`define ADDR_STAGE_INPUTS  12'h008
`define ADDR_BF_CFG        12'h00c
`define ADDR_BF_TIME       12'h010
`define ADDR_BF_STATUS     12'h014
`define ADDR_BF_ACK        12'h018

// stage setting bits, four per stage
`define CFG_FUNCTION       0
`define CFG_BLOCK_PERMIT   1
`define CFG_PERM_ORDER_BLK 2
`define CFG_ORDER_PERMIT   3
`define CFG_STRIDE         4
`define STAGE_CFG_RESET    16'h0000

// stage status bits, seven per stage, stride eight
`define ST_STRIDE          8
// stage input state bits, five per stage, stride eight
`define IN_STRIDE          8

// supervisor config fields
`define BF_SCHEME_LSB      0
`define BF_MODE_LSB        2
`define BF_CFG_RESET       4'h0
`define SCHEME_POSITION    2'h0
`define SCHEME_CURRENT     2'h1
`define SCHEME_BOTH        2'h2
`define MODE_NONE          2'h0
`define MODE_ALL           2'h1
`define MODE_CURRENT       2'h2
`define MODE_EXTERNAL      2'h3

// supervisor states
`define BF_STANDBY         2'h0
`define BF_RUNNING         2'h1
`define BF_REJECTED        2'h2
`define BF_FAILED          2'h3

// supervision time
// 100 ms at the 20 MHz clock, sized to the 24-bit timer
`define BF_TIME_CYCLES     24'h1e8480
`define TIMER_W            24

`endif

// *** src/external_protection_stage.v ***
// one external protection stage: settings and sources to output flags
`timescale 1ns/1ps
`default_nettype none
module external_protection_stage (
	input  wire       pclk,
	input  wire       presetn,
	input  wire [3:0] cfg,
	input  wire       ext_block_src1_state,
	input  wire       ext_block_src2_state,
	input  wire       ext_trip_order_block_src_state,
	input  wire       alarm_src_state,
	input  wire       trip_src_state,
	output reg  [6:0] flags
);
`include "prot_consts.vh"

	wire active;
	wire blocked;
	wire perm_blk;
	wire ext_ord_blk;
	wire alarm;
	wire trip;
	wire order;

	// a disabled stage produces nothing at all
	assign active = cfg[`CFG_FUNCTION];
	// blocking source matters only with its permission set
	assign blocked = active & cfg[`CFG_BLOCK_PERMIT] &
		(ext_block_src1_state | ext_block_src2_state);
	assign perm_blk = active & cfg[`CFG_PERM_ORDER_BLK];
	assign ext_ord_blk = active & ~blocked & cfg[`CFG_ORDER_PERMIT] &
		ext_trip_order_block_src_state;
	// blocked stage holds alarm and trip low
	assign alarm = active & ~blocked & alarm_src_state;
	assign trip = active & ~blocked & trip_src_state;
	assign order = trip & ~perm_blk & ~ext_ord_blk;

	// registered so the top sees flop outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 7'h00;
		end else begin
			flags <= {order, trip, alarm, ext_ord_blk, perm_blk,
				blocked, active};
		end
	end
endmodule // external_protection_stage
`default_nettype wire

// *** verification/supervisor_checker_asserts.sv ***
// port checker for the trip stages and breaker failure supervisor
`timescale 1ns/1ps
`default_nettype none
`include "prot_consts.vh"
module supervisor_checker #(
	parameter [23:0] BF_TIME_RESET = 24'h000014
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  stage_active,
	input wire logic [3:0]  ext_blocked_flag,
	input wire logic [3:0]  trip_order_blocked_flag,
	input wire logic [3:0]  ext_trip_order_blocked_flag,
	input wire logic [3:0]  stage_alarm,
	input wire logic [3:0]  stage_trip,
	input wire logic [3:0]  breaker_open_order,
	input wire logic        breaker_failure_trip,
	input wire logic        breaker_failure_lockout,
	input wire logic        supervisor_rejected,
	input wire logic        supervisor_running
);
	logic [24:0] run_cnt;
	wire ack_wr = psel && penable && pwrite &&
		paddr == `ADDR_BF_ACK && pwdata[0];
	wire [3:0] quiet = stage_alarm | stage_trip | breaker_open_order;
	wire [3:0] any_out = quiet | ext_blocked_flag |
		trip_order_blocked_flag | ext_trip_order_blocked_flag;
	// run length, so the failure moment can be bounded
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_cnt <= 25'h0;
		else
			run_cnt <= supervisor_running ? run_cnt + 25'h1 : 25'h0;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_off_silent; (any_out & ~stage_active) == 4'h0; endproperty
	a_off_silent: assert property (p_off_silent)
		else $error("flag raised by an inactive stage");
	property p_blk_quiet; (ext_blocked_flag & quiet) == 4'h0; endproperty
	a_blk_quiet: assert property (p_blk_quiet)
		else $error("blocked stage still alarms or trips");
	property p_perm_blk;
		(trip_order_blocked_flag & breaker_open_order) == 4'h0;
	endproperty
	a_perm_blk: assert property (p_perm_blk)
		else $error("open order despite permanent block");
	property p_ext_ord;
		(ext_trip_order_blocked_flag & breaker_open_order) == 4'h0;
	endproperty
	a_ext_ord: assert property (p_ext_ord)
		else $error("open order despite external order block");
	property p_ord_trip; (breaker_open_order & ~stage_trip) == 4'h0;
	endproperty
	a_ord_trip: assert property (p_ord_trip)
		else $error("open order without stage trip");
	property p_fail_time;
		$rose(breaker_failure_trip) |->
			run_cnt >= BF_TIME_RESET - 1 && run_cnt <= BF_TIME_RESET + 3;
	endproperty
	a_fail_time: assert property (p_fail_time)
		else $error("failure trip at wrong run length");
	property p_lock_trip; $rose(breaker_failure_trip) |->
		breaker_failure_lockout; endproperty
	a_lock_trip: assert property (p_lock_trip)
		else $error("lockout not with failure trip");
	property p_lock_hold; breaker_failure_lockout && !ack_wr &&
		!$past(ack_wr) && !$past(ack_wr, 2) |=> breaker_failure_lockout;
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("lockout cleared without acknowledge");
	property p_rej_run; $rose(supervisor_rejected) |->
		$past(supervisor_running) && !breaker_failure_trip; endproperty
	a_rej_run: assert property (p_rej_run)
		else $error("rejected not entered from a run");
	c_fail: cover property ($rose(breaker_failure_trip));
	c_rej: cover property ($rose(supervisor_rejected));
	c_ord: cover property ($rose(breaker_open_order[3]));
endmodule // supervisor_checker

bind ext_trip_and_breaker_fail_supervisor supervisor_checker #(
	.BF_TIME_RESET(BF_TIME_RESET)
) chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.stage_active, .ext_blocked_flag, .trip_order_blocked_flag,
	.ext_trip_order_blocked_flag, .stage_alarm, .stage_trip,
	.breaker_open_order, .breaker_failure_trip, .breaker_failure_lockout,
	.supervisor_rejected, .supervisor_running);
`default_nettype wire

// *** verification/breaker_model.sv ***
// supervised breaker: contacts part some cycles after an open command
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
	parameter int OPEN_DELAY = 5
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic open_cmd,
	input  wire logic stuck,
	output var  logic position_open,
	output var  logic current_below_threshold
);
	int cnt;
	// a stuck breaker never parts; recloses once the command drops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn || !open_cmd) begin
			cnt <= 0;
			position_open <= 1'b0;
		end else if (!stuck && cnt < OPEN_DELAY) begin
			cnt <= cnt + 1;
		end else if (!stuck) begin
			position_open <= 1'b1;
		end
	end
	// current collapses together with the contacts
	assign current_below_threshold = position_open;
endmodule // breaker_model
`default_nettype wire

// *** verification/ext_trip_and_breaker_fail_supervisor_test.sv ***
// bench: stage settings, supervisor runs and apb access
`timescale 1ns/1ps
`default_nettype none
`include "prot_consts.vh"
module ext_trip_and_breaker_fail_supervisor_test;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        all_trips, current_trips, external_trips, stuck, last_err;
	logic        freq_deviation_high, position_open, current_below_threshold;
	logic        breaker_failure_trip, breaker_failure_lockout;
	logic        supervisor_rejected, supervisor_running;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  extra_trigger;
	logic [3:0]  ext_block_src1, ext_block_src2, ext_trip_order_block_src;
	logic [3:0]  alarm_src, trip_src, stage_active, ext_blocked_flag;
	logic [3:0]  trip_order_blocked_flag, ext_trip_order_blocked_flag;
	logic [3:0]  stage_alarm, stage_trip, breaker_open_order;
	int          error_cnt, compares;
	ext_trip_and_breaker_fail_supervisor #(.BF_TIME_RESET(24'h000014)) dut_u (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_block_src1, .ext_block_src2,
		.ext_trip_order_block_src, .alarm_src, .trip_src, .all_trips,
		.current_trips, .external_trips, .extra_trigger,
		.current_below_threshold, .position_open, .freq_deviation_high,
		.stage_active, .ext_blocked_flag, .trip_order_blocked_flag,
		.ext_trip_order_blocked_flag, .stage_alarm, .stage_trip,
		.breaker_open_order, .breaker_failure_trip,
		.breaker_failure_lockout, .supervisor_rejected, .supervisor_running);
	breaker_model brk_u (.pclk, .presetn, .stuck, .position_open,
		.open_cmd(all_trips | current_trips | external_trips | |extra_trigger),
		.current_below_threshold);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; waits on pready, only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
		chk(last_err, 0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// bounded wait: 0 lockout, 1 failure trip, 2 rejected
	task automatic wait_for(input int k);
		int n;
		n = 0;
		while ((k == 0 ? breaker_failure_lockout : k == 1 ?
			breaker_failure_trip : supervisor_rejected) !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 300) chk(0, 1);
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog: the whole run needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		close_out;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_block_src1, ext_block_src2, ext_trip_order_block_src} = '0;
		{alarm_src, trip_src, extra_trigger, freq_deviation_high} = '0;
		{all_trips, current_trips, external_trips, stuck} = '0;
		{error_cnt, compares} = '0;
		tick(16);
		presetn <= 1'b1;
		tick(1);
		rd(`ADDR_STAGE_CFG, 32'h0);
		rd(`ADDR_BF_TIME, 32'h14);
		rd(12'h01c, 32'h0);
		chk(last_err, 1);
		trip_src <= 4'hf;
		alarm_src <= 4'hf;
		tick(8);
		chk(stage_trip | stage_alarm | stage_active, 0);
		rd(`ADDR_STAGE_INPUTS, 32'h18181818);
		$display("reset and disabled stages done");
		wr(`ADDR_STAGE_CFG, 32'h1111);
		tick(8);
		chk(breaker_open_order, 4'hf);
		rd(`ADDR_STAGE_STATUS, 32'h71717171);
		ext_block_src1 <= 4'h3;
		ext_block_src2 <= 4'hc;
		wr(`ADDR_STAGE_CFG, 32'h1133);
		tick(8);
		chk({ext_blocked_flag, stage_trip}, 8'h3c);
		chk(stage_alarm, 4'hc);
		{ext_block_src1, ext_block_src2} <= 8'h0;
		ext_trip_order_block_src <= 4'h2;
		wr(`ADDR_STAGE_CFG, 32'h1195);
		tick(8);
		chk({stage_trip, breaker_open_order}, 8'hfc);
		chk(trip_order_blocked_flag, 4'h1);
		chk(ext_trip_order_blocked_flag, 4'h2);
		wr(`ADDR_STAGE_CFG, 32'h0);
		{trip_src, alarm_src, ext_trip_order_block_src} <= '0;
		$display("stage settings done");
		stuck <= 1'b1;
		extra_trigger <= 3'h1;
		tick(3);
		extra_trigger <= 3'h0;
		wait_for(0);
		chk(breaker_failure_lockout, 1);
		wr(`ADDR_BF_ACK, 32'h1);
		tick(3);
		chk(breaker_failure_lockout, 0);
		wr(`ADDR_BF_CFG, 32'h4);
		all_trips <= 1'b1;
		wait_for(1);
		rd(`ADDR_BF_STATUS, 32'h0f);
		all_trips <= 1'b0;
		tick(6);
		chk({breaker_failure_trip, breaker_failure_lockout}, 2'b01);
		wr(`ADDR_BF_ACK, 32'h1);
		$display("failure runs done");
		stuck <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(`ADDR_BF_CFG, (i + 1) * 4 + i);
			{all_trips, current_trips, external_trips} <= 3'b100 >> i;
			wait_for(2);
			chk(breaker_failure_trip, 0);
			tick(10);
			chk(supervisor_rejected, 1);
			{all_trips, current_trips, external_trips} <= 3'b000;
			tick(6);
			rd(`ADDR_BF_STATUS, 32'h0);
		end
		// breaker opens after the trigger pulse: plain stand-by, no lockout
		wr(`ADDR_BF_CFG, 32'h0);
		{all_trips, extra_trigger} <= 4'h9;
		tick(3);
		extra_trigger <= 3'h0;
		tick(30);
		chk({supervisor_running, supervisor_rejected,
			breaker_failure_lockout}, 3'h0);
		all_trips <= 1'b0;
		// stuck breaker, so a run that should not start would trip
		wr(`ADDR_BF_CFG, 32'h5);
		freq_deviation_high <= 1'b1;
		stuck <= 1'b1;
		all_trips <= 1'b1;
		tick(30);
		chk({supervisor_running, breaker_failure_trip}, 2'b00);
		all_trips <= 1'b0;
		$display("reject and scheme runs done");
		close_out;
	end
endmodule // ext_trip_and_breaker_fail_supervisor_test
`default_nettype wire
